/* hw/htic_pkg.sv */
// Purpose: shared constants, types and register map of the hardware timer and input capture block
// Assumes: one 100 MHz clock, synchronous active-high reset, APB slave with 32-bit data
// Notes: registers sit at their full printed byte addresses; status, match and count words are
//   extra words beside them
package htic_pkg;

  // register byte addresses
  localparam logic [31:0] HTIC_CTRL_ADDR = 32'h4000_0014;
  localparam logic [31:0] HTIC_T1_ADDR = 32'h4000_0018;
  localparam logic [31:0] HTIC_T2_ADDR = 32'h4000_001C;
  localparam logic [31:0] HTIC_T3_ADDR = 32'h4000_0020;
  localparam logic [31:0] HTIC_MATCH1_ADDR = 32'h4000_0024;
  localparam logic [31:0] HTIC_MATCH2_ADDR = 32'h4000_0028;
  localparam logic [31:0] HTIC_STATUS_ADDR = 32'h4000_002C;
  localparam logic [31:0] HTIC_T3CNT_ADDR = 32'h4000_0030;

  // reset values and masks
  localparam logic [31:0] HTIC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HTIC_CTRL_MASK = 32'h0007_FFFF;
  localparam logic [31:0] HTIC_VALUE_RST = 32'h0000_0000;
  localparam logic [31:0] HTIC_MATCH_RST = 32'hFFFF_FFFF;
  localparam logic [7:0] HTIC_STATUS_RST = 8'h00;

  // status bit positions
  localparam int HTIC_ST_CAP_LSB = 0;
  localparam int HTIC_ST_MATCH_LSB = 4;

  // control word, bit 31 down to bit 0
  typedef struct packed {
    logic [12:0] rsvd;
    logic third_timer_busy;
    logic second_timer_busy;
    logic first_timer_busy;
    logic [4:0] cap_b_line_select;
    logic cap_b_enable;
    logic [1:0] cap_b_edge_mode;
    logic [4:0] cap_a_line_select;
    logic cap_a_enable;
    logic [1:0] cap_a_edge_mode;
  } htic_ctrl_t;

  typedef enum logic [1:0] {
    HTIC_RISE_RISE = 2'h0,
    HTIC_FALL_FALL = 2'h1,
    HTIC_RISE_FALL = 2'h2,
    HTIC_FALL_RISE = 2'h3
  } htic_edge_mode_t;

  // one capture channel's settings
  typedef struct packed {
    logic [4:0] line_select;
    logic enable;
    htic_edge_mode_t edge_mode;
  } htic_cap_cfg_t;

  typedef enum logic [3:0] {
    HTIC_REG_CTRL = 4'h0,
    HTIC_REG_T1 = 4'h1,
    HTIC_REG_T2 = 4'h2,
    HTIC_REG_T3 = 4'h3,
    HTIC_REG_MATCH1 = 4'h4,
    HTIC_REG_MATCH2 = 4'h5,
    HTIC_REG_STATUS = 4'h6,
    HTIC_REG_T3CNT = 4'h7,
    HTIC_REG_NONE = 4'hF
  } htic_reg_t;

  typedef enum logic [1:0] {
    HTIC_CAP_IDLE = 2'h0,
    HTIC_CAP_ARM = 2'h1,
    HTIC_CAP_MEASURE = 2'h2
  } htic_cap_state_t;

endpackage

/* hw/htic_capture.sv */
// Purpose: one input capture channel measuring edge intervals of a selected gpio line
// Assumes: gpio lines are asynchronous to clk
// Notes: result is the number of clk cycles between the two qualifying edges
`timescale 1ns/100ps
module htic_capture import htic_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input htic_cap_cfg_t cfg,
  input wire logic [31:0] gpio_i,
  output logic [31:0] result_q,
  output logic done_q
);

  logic [31:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic prev_q, prev_d, sel;
  logic [31:0] cnt_q, cnt_d, result_d;
  logic done_d, rise, fall, start_edge, end_edge;
  htic_cap_state_t state_q, state_d;

  function automatic logic pick_edge(logic want_rise, logic r, logic f);
    return want_rise ? r : f;
  endfunction

  // every line is synchronised before the select mux; the first stage feeds only the second
  always_comb begin
    sync1_d = gpio_i;
    sync2_d = sync1_q;
    sel = sync2_q[cfg.line_select];
    prev_d = sel;
    rise = sel & ~prev_q;
    fall = ~sel & prev_q;
    start_edge = pick_edge(~cfg.edge_mode[0], rise, fall);
    end_edge = pick_edge(~(cfg.edge_mode[0] ^ cfg.edge_mode[1]), rise, fall);
  end

  // interval state machine; counter saturates rather than wrapping
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    result_d = result_q;
    done_d = 1'b0;
    case (state_q)
      HTIC_CAP_IDLE: begin
        if (cfg.enable) begin
          state_d = HTIC_CAP_ARM;
        end
      end
      HTIC_CAP_ARM: begin
        if (start_edge) begin
          state_d = HTIC_CAP_MEASURE;
          cnt_d = 32'h0000_0001;
        end
      end
      HTIC_CAP_MEASURE: begin
        if (end_edge) begin
          result_d = cnt_q;
          done_d = 1'b1;
          if (cfg.edge_mode[1]) begin
            state_d = HTIC_CAP_ARM;
          end else begin
            cnt_d = 32'h0000_0001;
          end
        end else if (cnt_q != 32'hFFFF_FFFF) begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      default: begin
        state_d = HTIC_CAP_IDLE;
      end
    endcase
    if (!cfg.enable) begin
      // an end edge in the cycle the channel is switched off must not report a result
      state_d = HTIC_CAP_IDLE;
      cnt_d = 32'h0000_0000;
      result_d = result_q;
      done_d = 1'b0;
    end
  end

  // all state frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 32'h0000_0000;
      sync2_q <= 32'h0000_0000;
      prev_q <= 1'b0;
      state_q <= HTIC_CAP_IDLE;
      cnt_q <= 32'h0000_0000;
      result_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      result_q <= result_d;
      done_q <= done_d;
    end
  end

  rise_rise_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (state_q == HTIC_CAP_MEASURE && cfg.enable && cfg.edge_mode == HTIC_RISE_RISE && rise)
    |=> done_q && result_q == $past(cnt_q) && state_q == HTIC_CAP_MEASURE)
    else $error("rising interval not captured");
  fall_fall_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (state_q == HTIC_CAP_MEASURE && cfg.enable && cfg.edge_mode == HTIC_FALL_FALL && fall)
    |=> done_q && cnt_q == 32'h0000_0001)
    else $error("falling interval not captured");
  rise_fall_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (state_q == HTIC_CAP_MEASURE && cfg.enable && cfg.edge_mode == HTIC_RISE_FALL && fall)
    |=> done_q && state_q == HTIC_CAP_ARM)
    else $error("rise to fall width not captured");
  fall_rise_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (state_q == HTIC_CAP_MEASURE && cfg.enable && cfg.edge_mode == HTIC_FALL_RISE && rise)
    |=> done_q && state_q == HTIC_CAP_ARM)
    else $error("fall to rise width not captured");
  cap_disabled_a: assert property (@(posedge clk) disable iff (rst || !ce)
    !cfg.enable |=> state_q == HTIC_CAP_IDLE && !done_q)
    else $error("capture active while disabled");
  cap_done_c: cover property (@(posedge clk) disable iff (rst) done_q);

endmodule

/* hw/htic_timer_top.sv */
// Purpose: three hardware timers with two input capture channels behind an APB slave
// Assumes: APB master follows setup and access phases; gpio lines are asynchronous
// Notes: zero-wait answer; read data is sampled in the setup cycle; ce low freezes everything
`timescale 1ns/100ps
module htic_timer_top import htic_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] gpio_i,
  output logic [2:0] timer_match,
  output logic [1:0] capture_done
);

  htic_ctrl_t ctrl_q, ctrl_d;
  logic [31:0] tval_q [0:1];
  logic [31:0] tval_d [0:1];
  logic [31:0] match_q [0:1];
  logic [31:0] match_d [0:1];
  logic [31:0] t3_timeout_q, t3_timeout_d, t3_cnt_q, t3_cnt_d;
  logic [7:0] status_q, status_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [2:0] match_q_pulse, match_d_pulse;
  logic [1:0] cap_pulse_q, cap_pulse_d;
  logic [31:0] cap_result [0:1];
  logic [1:0] cap_done;
  htic_cap_cfg_t cap_cfg [0:1];
  logic [1:0] cap_en;
  logic [2:0] busy, hits;
  logic setup, wr_acc;
  htic_reg_t rd_idx, wr_idx;

  // address decode, shared by the read and the write path
  function automatic htic_reg_t reg_index(logic [31:0] addr);
    if (addr == HTIC_CTRL_ADDR) begin
      return HTIC_REG_CTRL;
    end else if (addr == HTIC_T1_ADDR) begin
      return HTIC_REG_T1;
    end else if (addr == HTIC_T2_ADDR) begin
      return HTIC_REG_T2;
    end else if (addr == HTIC_T3_ADDR) begin
      return HTIC_REG_T3;
    end else if (addr == HTIC_MATCH1_ADDR) begin
      return HTIC_REG_MATCH1;
    end else if (addr == HTIC_MATCH2_ADDR) begin
      return HTIC_REG_MATCH2;
    end else if (addr == HTIC_STATUS_ADDR) begin
      return HTIC_REG_STATUS;
    end else if (addr == HTIC_T3CNT_ADDR) begin
      return HTIC_REG_T3CNT;
    end else begin
      return HTIC_REG_NONE;
    end
  endfunction

  // channel settings picked out of the control word
  always_comb begin
    cap_cfg[0] = {ctrl_q.cap_a_line_select, ctrl_q.cap_a_enable,
                  htic_edge_mode_t'(ctrl_q.cap_a_edge_mode)};
    cap_cfg[1] = {ctrl_q.cap_b_line_select, ctrl_q.cap_b_enable,
                  htic_edge_mode_t'(ctrl_q.cap_b_edge_mode)};
    cap_en = {ctrl_q.cap_b_enable, ctrl_q.cap_a_enable};
    busy = {ctrl_q.third_timer_busy, ctrl_q.second_timer_busy, ctrl_q.first_timer_busy};
  end

  // only the first two timers own a capture channel
  for (genvar g = 0; g < 2; g++) begin : g_cap
    htic_capture u_cap (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .cfg(cap_cfg[g]),
      .gpio_i(gpio_i),
      .result_q(cap_result[g]),
      .done_q(cap_done[g])
    );
  end

  // apb: answer is prepared in the setup cycle, so pready is high in the first access cycle
  always_comb begin
    setup = psel & ~penable & ~pready_q;
    wr_acc = psel & penable & pready_q & pwrite & ~pslverr_q;
    rd_idx = reg_index(paddr);
    wr_idx = wr_acc ? reg_index(paddr) : HTIC_REG_NONE;
    pready_d = setup;
    pslverr_d = setup & (rd_idx == HTIC_REG_NONE);
    prdata_d = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (rd_idx == HTIC_REG_CTRL) begin
        prdata_d = ctrl_q;
      end else if (rd_idx == HTIC_REG_T1) begin
        prdata_d = tval_q[0];
      end else if (rd_idx == HTIC_REG_T2) begin
        prdata_d = tval_q[1];
      end else if (rd_idx == HTIC_REG_T3) begin
        prdata_d = t3_timeout_q;
      end else if (rd_idx == HTIC_REG_MATCH1) begin
        prdata_d = match_q[0];
      end else if (rd_idx == HTIC_REG_MATCH2) begin
        prdata_d = match_q[1];
      end else if (rd_idx == HTIC_REG_STATUS) begin
        prdata_d = {24'h00_0000, status_q};
      end else if (rd_idx == HTIC_REG_T3CNT) begin
        prdata_d = t3_cnt_q;
      end
    end
  end

  // timers: count while busy (the first two only while their capture channel is off), stop and drop busy on reaching the match point
  always_comb begin
    ctrl_d = ctrl_q;
    t3_timeout_d = t3_timeout_q;
    t3_cnt_d = t3_cnt_q;
    hits = 3'h0;
    for (int i = 0; i < 2; i++) begin
      tval_d[i] = tval_q[i];
      match_d[i] = match_q[i];
      if (cap_done[i]) begin
        tval_d[i] = cap_result[i];
      end else if (busy[i] && !cap_en[i]) begin
        tval_d[i] = tval_q[i] + 32'h0000_0001;
        hits[i] = (tval_q[i] + 32'h0000_0001) == match_q[i];
      end
    end
    if (busy[2]) begin
      t3_cnt_d = t3_cnt_q + 32'h0000_0001;
      hits[2] = (t3_cnt_q + 32'h0000_0001) == t3_timeout_q;
    end
    // completion drops busy; a software write in the same cycle overrides it
    ctrl_d.first_timer_busy = busy[0] & ~hits[0];
    ctrl_d.second_timer_busy = busy[1] & ~hits[1];
    ctrl_d.third_timer_busy = busy[2] & ~hits[2];
    if (wr_idx == HTIC_REG_CTRL) begin
      // software is trusted to leave busy low while capture is enabled
      ctrl_d = htic_ctrl_t'(pwdata & HTIC_CTRL_MASK);
      if (pwdata[$bits(htic_ctrl_t) - 14] && !busy[2]) begin
        t3_cnt_d = 32'h0000_0000;
      end
    end
    // a timer word is read-only while its channel captures
    if (wr_idx == HTIC_REG_T1 && !cap_en[0]) begin
      tval_d[0] = pwdata;
    end
    if (wr_idx == HTIC_REG_T2 && !cap_en[1]) begin
      tval_d[1] = pwdata;
    end
    if (wr_idx == HTIC_REG_T3) begin
      t3_timeout_d = pwdata;
    end
    if (wr_idx == HTIC_REG_MATCH1) begin
      match_d[0] = pwdata;
    end
    if (wr_idx == HTIC_REG_MATCH2) begin
      match_d[1] = pwdata;
    end
  end

  // sticky status, write one to clear; a new event in the clearing cycle wins
  always_comb begin
    status_d = status_q;
    if (wr_idx == HTIC_REG_STATUS) begin
      status_d = status_q & ~pwdata[7:0];
    end
    status_d[HTIC_ST_CAP_LSB +: 2] = status_d[HTIC_ST_CAP_LSB +: 2] | cap_done;
    status_d[HTIC_ST_MATCH_LSB +: 3] = status_d[HTIC_ST_MATCH_LSB +: 3] | hits;
    match_d_pulse = hits;
    cap_pulse_d = cap_done;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= htic_ctrl_t'(HTIC_CTRL_RST);
      tval_q[0] <= HTIC_VALUE_RST;
      tval_q[1] <= HTIC_VALUE_RST;
      match_q[0] <= HTIC_MATCH_RST;
      match_q[1] <= HTIC_MATCH_RST;
      t3_timeout_q <= HTIC_VALUE_RST;
      t3_cnt_q <= HTIC_VALUE_RST;
      status_q <= HTIC_STATUS_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      match_q_pulse <= 3'h0;
      cap_pulse_q <= 2'h0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      tval_q[0] <= tval_d[0];
      tval_q[1] <= tval_d[1];
      match_q[0] <= match_d[0];
      match_q[1] <= match_d[1];
      t3_timeout_q <= t3_timeout_d;
      t3_cnt_q <= t3_cnt_d;
      status_q <= status_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      match_q_pulse <= match_d_pulse;
      cap_pulse_q <= cap_pulse_d;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_match = match_q_pulse;
  assign capture_done = cap_pulse_q;

  apb_answer_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (psel && !penable && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("apb answer not one cycle after setup");
  t1_count_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (busy[0] && !cap_en[0] && !cap_done[0] && wr_idx == HTIC_REG_NONE)
    |=> tval_q[0] == $past(tval_q[0]) + 32'h0000_0001)
    else $error("first timer did not advance");
  t3_timeout_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (busy[2] && t3_cnt_q + 32'h0000_0001 == t3_timeout_q && wr_idx != HTIC_REG_CTRL)
    |=> !ctrl_q.third_timer_busy && timer_match[2] && status_q[HTIC_ST_MATCH_LSB + 2])
    else $error("third timer timeout not signalled");
  cap_latch_a: assert property (@(posedge clk) disable iff (rst || !ce)
    cap_done[0] |=> tval_q[0] == $past(cap_result[0]) && capture_done[0])
    else $error("capture result not latched into first timer");
  cap_ro_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (wr_idx == HTIC_REG_T2 && cap_en[1] && !cap_done[1]) |=> $stable(tval_q[1]))
    else $error("second timer written during capture");
  busy3_rw_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (wr_idx == HTIC_REG_CTRL) |=> ctrl_q.third_timer_busy == $past(pwdata[18])
      && ctrl_q.rsvd == 13'h0000)
    else $error("third busy bit not written");
  match_flag_a: assert property (@(posedge clk) disable iff (rst || !ce)
    (hits[1] && wr_idx != HTIC_REG_CTRL)
      |=> timer_match[1] && status_q[HTIC_ST_MATCH_LSB + 1] && !ctrl_q.second_timer_busy
      ##1 !timer_match[1] || !ce)
    else $error("match event lost");
  t3_match_c: cover property (@(posedge clk) disable iff (rst) timer_match[2]);
  slverr_c: cover property (@(posedge clk) disable iff (rst) pslverr_q);
  cap_b_c: cover property (@(posedge clk) disable iff (rst) capture_done[1]);

endmodule

/* testbench/htic_gpio_model.sv */
// Purpose: far-side gpio source whose selected line carries a square wave
// Assumes: lengths are clk cycles and non-zero; changes only just after a rising edge
// Notes: every other line toggles each cycle, so a wrong line select shows up at once
`timescale 1ns/100ps
module htic_gpio_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [4:0] line,
  input wire logic [15:0] hi_len,
  input wire logic [15:0] lo_len,
  output logic [31:0] gpio_o
);
  logic [15:0] cnt_q;
  logic lvl_q;
  logic [31:0] noise_q = 32'hA5A5_A5A5;

  // wave stays low while stopped; high lasts hi_len cycles, low lasts lo_len cycles
  always @(posedge clk) begin
    noise_q <= ~noise_q;
    if (!run) begin
      cnt_q <= 16'h0000;
      lvl_q <= 1'b0;
    end else if (cnt_q + 16'h0001 >= (lvl_q ? hi_len : lo_len)) begin
      cnt_q <= 16'h0000;
      lvl_q <= ~lvl_q;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // unselected lines never sit still, so they cannot pass for the measured one
  always_comb begin
    gpio_o = noise_q;
    gpio_o[line] = lvl_q;
  end
endmodule

/* testbench/test_hw_timer_input_capture.sv */
// Purpose: self-checking bench for the timers and capture channels over apb
// Assumes: zero-wait apb slave; gpio wave from the partner model
// Notes: outputs are sampled in the active region after an edge, before the design updates
`timescale 1ns/100ps
module test_hw_timer_input_capture import htic_pkg::*;;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, err, run;
  logic [31:0] paddr, pwdata, prdata, gpio_i, rd;
  logic [2:0] timer_match;
  logic [1:0] capture_done;
  logic [4:0] line;
  logic [15:0] hi_len, lo_len;
  logic [7:0] cfg;
  logic [31:0] exp_v, t_addr;
  int error_cnt, n_checks, k;
  wire [4:0] ev = {capture_done, timer_match};

  htic_timer_top DUT (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_i(gpio_i), .timer_match(timer_match),
    .capture_done(capture_done));
  htic_gpio_model gpio_src (.clk(clk), .run(run), .line(line), .hi_len(hi_len),
    .lo_len(lo_len), .gpio_o(gpio_i));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer; an idle edge follows so no signal is driven twice in one step
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // bounded wait for one event pulse; k counts the edges it took
  task automatic wait_ev(input int w);
    k = 0;
    while (ev[w] !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (ev[w] !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
  endtask

  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    run = 1'b0;
    line = 5'h00;
    hi_len = 16'h0007;
    lo_len = 16'h0004;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values from the register table
    rdc(HTIC_CTRL_ADDR, 32'h0000_0000);
    rdc(HTIC_T1_ADDR, 32'h0000_0000);
    rdc(HTIC_T2_ADDR, 32'h0000_0000);
    rdc(HTIC_T3_ADDR, 32'h0000_0000);
    apb(1'b0, 32'h4000_0034, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    // control fields read back, upper bits stay zero; the third busy bit is then set and read back too
    wr(HTIC_CTRL_ADDR, 32'hFFF8_FFFF);
    rdc(HTIC_CTRL_ADDR, 32'h0000_FFFF);
    wr(HTIC_CTRL_ADDR, 32'h0000_0000);
    wr(HTIC_CTRL_ADDR, 32'h0004_0000);
    rdc(HTIC_CTRL_ADDR, 32'h0004_0000);
    wr(HTIC_CTRL_ADDR, 32'h0000_0000);
    // third timer: timeout 3 completes three edges after the write
    wr(HTIC_T3_ADDR, 32'h0000_0003);
    rdc(HTIC_T3_ADDR, 32'h0000_0003);
    wr(HTIC_CTRL_ADDR, 32'h0004_0000);
    wait_ev(2);
    check(32'(k), 32'h0000_0003);
    rdc(HTIC_CTRL_ADDR, 32'h0000_0000);
    rdc(HTIC_T3CNT_ADDR, 32'h0000_0003);
    // first and second timers count to their match point, capture enables held at zero
    for (int i = 0; i < 2; i++) begin
      t_addr = i ? HTIC_T2_ADDR : HTIC_T1_ADDR;
      wr(t_addr, 32'h0000_0000);
      wr(i ? HTIC_MATCH2_ADDR : HTIC_MATCH1_ADDR, 32'h0000_0005);
      wr(HTIC_CTRL_ADDR, 32'h0000_0001 << (16 + i));
      wait_ev(i);
      check(32'(k), 32'h0000_0005);
      rdc(t_addr, 32'h0000_0005);
      rdc(HTIC_CTRL_ADDR, 32'h0000_0000);
    end
    // all three match flags are sticky until written one
    apb(1'b0, HTIC_STATUS_ADDR, 32'h0000_0000);
    check(rd & 32'h0000_0070, 32'h0000_0070);
    wr(HTIC_STATUS_ADDR, 32'h0000_00FF);
    rdc(HTIC_STATUS_ADDR, 32'h0000_0000);
    // every edge mode on both channels; high 7 cycles, low 4
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 4; m++) begin
        t_addr = ch ? HTIC_T2_ADDR : HTIC_T1_ADDR;
        run <= 1'b0;
        line <= ch ? 5'h0C : 5'h05;
        @(posedge clk);
        run <= 1'b1;
        cfg = {(ch ? 5'h0C : 5'h05), 1'b1, 2'(m)};
        exp_v = (m < 2) ? 32'h0000_000B : ((m == 2) ? 32'h0000_0007 : 32'h0000_0004);
        wr(HTIC_CTRL_ADDR, 32'(cfg) << (8 * ch));
        wait_ev(3 + ch);
        rdc(t_addr, exp_v);
        wr(t_addr, 32'h0000_1234);
        rdc(t_addr, exp_v);
        wr(HTIC_CTRL_ADDR, 32'h0000_0000);
        // with capture off the word is writable again
        wr(t_addr, 32'h0000_1234);
        rdc(t_addr, 32'h0000_1234);
      end
    end
    complete_run();
  end
endmodule
